/* core/apsp_axis.sv */
// axis protection and status parameter block with AHB-Lite registers
// Summary of operation
// (R01) freewheel select, codes 0 to 3, 0 normal, drives standstill option
// (R02) read-only load value 0..1023 from stall detection
// (R03) extended errors: bit0 stall, bit1 deviation; a read clears both
// (R04) any motion command also clears both extended error flags
// (R05) fault bits: 0 stall, 1 overtemperature shutdown, 2 pre-warning
// (R06) fault bits 3/4: short to ground coil A/B, driver held off
// (R07) fault bits 5/6: open load, no chopper event in last polarity period
// (R08) fault bit 7: standstill, no step pulse in last 2^20 cycles
// (R09) encoder counts per revolution 0..65535, read and write
// (R10) stop motor when position minus encoder exceeds maximum deviation
// (R11) maximum deviation of zero disables the deviation monitor
// (R12) after power-down delay of standstill, in 10 ms units, reduce current
// (R13) power-down delay resets to 200 units, 2000 ms
// (R14) unit mode 0: velocity and acceleration in internal units
// (R15) unit mode 1, the default: pps and pps squared
// (R16) a deviation stop also sets the deviation error flag
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "apsp_cfg.svh"
module apsp_axis #(
  parameter int STILL_CYCLES = 2 ** `APSP_STILL_LOG2,
  parameter int PD_TICK_CYCLES =
    (`APSP_PD_UNIT_MS * 1000000) / `APSP_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic        hresp,
  output      logic [31:0] hrdata,
  // driver stage and motion core
  input  wire logic [9:0]  load_value,
  input  wire logic        stall_detect,
  input  wire logic        overtemp,
  input  wire logic        temp_prewarn,
  input  wire logic        short_a,
  input  wire logic        short_b,
  input  wire logic        chop_event_a,
  input  wire logic        chop_event_b,
  input  wire logic        coil_pol_a,
  input  wire logic        coil_pol_b,
  input  wire logic        step_pulse,
  input  wire logic        motion_cmd,
  input  wire logic [31:0] actual_pos,
  // encoder
  input  wire logic        enc_up,
  input  wire logic        enc_down,
  // control outputs
  output      logic        motor_stop,
  output      logic        current_reduce,
  output      logic        driver_off,
  output      logic [1:0]  freewheel_mode,
  output      logic        unit_pps,
  output      logic [15:0] enc_counts_per_rev,
  output      logic        irq
);
  import apsp_pkg::*;

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  apsp_state_s q;
  apsp_state_s next_q;
  logic        off_q;

  // byte address to register index, or 8'h00 when misaligned/out of map
  function automatic logic [7:0] idx_of(input logic [31:0] a);
    if (a[1:0] != 2'h0 || a[31:10] != 22'h0) begin
      idx_of = 8'h00;
    end else begin
      idx_of = a[9:2];
    end
  endfunction : idx_of

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  logic        take;
  logic        wr;
  logic        rd_ext;
  logic [7:0]  ridx;
  logic [31:0] diff;
  logic [31:0] mag;
  logic        dev_trip;
  logic        stall_ev;
  logic [2:0]  ev;
  logic        open_a;
  logic        open_b;

  // one process computes the whole next state except off_q; every field of next_q
  // starts as the held value so that a path which does not touch a
  // field keeps it, and no latch can be inferred for any part of it.
  // the helper variables below are given a value on every path too.
  always_comb begin
    next_q = q;
    take   = hsel && htrans[1] && hready;
    ridx   = idx_of(haddr);
    wr     = q.ap_valid && q.ap_write;
    rd_ext = take && !hwrite && ridx == `APSP_IDX_EXT_ERR;
    // deviation between commanded and encoder position
    diff   = actual_pos - q.enc_cnt;
    mag    = diff[31] ? (32'h0 - diff) : diff;
    dev_trip = (q.max_dev != 16'h0) &&                   // [R11]
               (mag > {16'h0, q.max_dev});               // [R10]
    stall_ev = stall_detect;
    open_a = 1'b0;
    open_b = 1'b0;

    // address phase capture and registered read data
    // read data is built from the address phase, so the slave never
    // stalls; hrdata returns to zero outside a read data phase.
    // a read of the extended errors both shows and clears them here,
    // the shown value being the one held before the clear.
    next_q.ap_valid = take;
    next_q.ap_write = hwrite;
    next_q.ap_idx   = ridx;
    next_q.hrdata   = 32'h0;
    if (take && !hwrite) begin
      if (ridx == `APSP_IDX_FREEWHEEL) begin
        next_q.hrdata = {30'h0, q.freewheel};
      end else if (ridx == `APSP_IDX_LOAD) begin
        next_q.hrdata = {22'h0, load_value};             // [R02]
      end else if (ridx == `APSP_IDX_EXT_ERR) begin
        next_q.hrdata = {30'h0, q.ext_err};              // [R03]
      end else if (ridx == `APSP_IDX_DRV_FAULT) begin
        next_q.hrdata = {24'h0, q.drv};
      end else if (ridx == `APSP_IDX_ENC_CNT) begin
        next_q.hrdata = q.enc_cnt;
      end else if (ridx == `APSP_IDX_ENC_RES) begin
        next_q.hrdata = {16'h0, q.enc_res};              // [R09]
      end else if (ridx == `APSP_IDX_MAX_DEV) begin
        next_q.hrdata = {16'h0, q.max_dev};
      end else if (ridx == `APSP_IDX_PD_DELAY) begin
        next_q.hrdata = {23'h0, q.pd_delay};
      end else if (ridx == `APSP_IDX_IRQ_STATUS) begin
        next_q.hrdata = {29'h0, q.irq_st};
      end else if (ridx == `APSP_IDX_IRQ_MASK) begin
        next_q.hrdata = {29'h0, q.irq_mask};
      end else if (ridx == `APSP_IDX_UNIT) begin
        next_q.hrdata = {31'h0, q.unit};
      end
    end

    // encoder counter: counts every cycle exactly one count line is high, software write overrides
    // the counter wraps at the word boundary in both directions; a
    // pulse on both count lines at once is taken as no movement.
    if (enc_up && !enc_down) begin
      next_q.enc_cnt = q.enc_cnt + 32'h1;
    end else if (enc_down && !enc_up) begin
      next_q.enc_cnt = q.enc_cnt - 32'h1;
    end

    // data phase writes
    // writes to read-only or unmapped indices fall through and are
    // ignored; narrow fields take the low bits of the data word.
    if (wr) begin
      if (q.ap_idx == `APSP_IDX_FREEWHEEL) begin
        next_q.freewheel = hwdata[1:0];                  // [R01]
      end else if (q.ap_idx == `APSP_IDX_ENC_CNT) begin
        next_q.enc_cnt = hwdata;
      end else if (q.ap_idx == `APSP_IDX_ENC_RES) begin
        next_q.enc_res = hwdata[15:0];                   // [R09]
      end else if (q.ap_idx == `APSP_IDX_MAX_DEV) begin
        next_q.max_dev = hwdata[15:0];
      end else if (q.ap_idx == `APSP_IDX_PD_DELAY) begin
        next_q.pd_delay = hwdata[8:0];                   // [R12]
      end else if (q.ap_idx == `APSP_IDX_IRQ_MASK) begin
        next_q.irq_mask = hwdata[2:0];
      end else if (q.ap_idx == `APSP_IDX_UNIT) begin
        next_q.unit = hwdata[0];                         // [R14] [R15]
      end
    end

    // extended errors: read or motion command clears, new event wins
    if (rd_ext || motion_cmd) begin                      // [R03] [R04]
      next_q.ext_err = 2'h0;
    end
    if (stall_ev) begin
      next_q.ext_err[`APSP_EXT_STALL] = 1'b1;
    end
    if (dev_trip) begin
      next_q.ext_err[`APSP_EXT_DEV] = 1'b1;              // [R16]
    end

    // deviation stop holds until the next motion command
    // while the deviation stays above the limit the stop is set again
    // each cycle, so a motion command alone cannot restart the motor.
    if (dev_trip) begin
      next_q.stop = 1'b1;                                // [R10]
    end else if (motion_cmd) begin
      next_q.stop = 1'b0;
    end

    // open load: a polarity period ended with no chopper event
    // a chopper event in the very cycle of the polarity change counts
    // for the new period, not for the one that has just ended.
    next_q.pol_a  = coil_pol_a;
    next_q.pol_b  = coil_pol_b;
    next_q.chop_a = q.chop_a || chop_event_a;
    next_q.chop_b = q.chop_b || chop_event_b;
    if (coil_pol_a != q.pol_a) begin
      open_a        = !q.chop_a;                         // [R07]
      next_q.chop_a = chop_event_a;
    end
    if (coil_pol_b != q.pol_b) begin
      open_b        = !q.chop_b;                         // [R07]
      next_q.chop_b = chop_event_b;
    end

    // standstill counter, saturating at the limit
    if (step_pulse) begin
      next_q.still_cnt = 32'h0;
    end else if (q.still_cnt < STILL_CYCLES) begin
      next_q.still_cnt = q.still_cnt + 32'h1;
    end

    // driver fault flags
    next_q.drv[`APSP_DRV_STALL]   = stall_detect;        // [R05]
    next_q.drv[`APSP_DRV_OTEMP]   = overtemp;            // [R05]
    next_q.drv[`APSP_DRV_PREWARN] = temp_prewarn;        // [R05]
    next_q.drv[`APSP_DRV_SHORT_A] = short_a;             // [R06]
    next_q.drv[`APSP_DRV_SHORT_B] = short_b;             // [R06]
    if (coil_pol_a != q.pol_a) begin
      next_q.drv[`APSP_DRV_OPEN_A] = open_a;
    end
    if (coil_pol_b != q.pol_b) begin
      next_q.drv[`APSP_DRV_OPEN_B] = open_b;
    end
    next_q.drv[`APSP_DRV_STILL] =
      !step_pulse && (next_q.still_cnt >= STILL_CYCLES); // [R08]

    // power-down delay in 10 ms units while no step occurs
    // a delay of zero reduces the current two cycles after the last
    // step; any step pulse restarts the whole delay from zero.
    if (step_pulse) begin
      next_q.tick_cnt = 32'h0;
      next_q.pd_units = 9'h0;
      next_q.reduce   = 1'b0;
    end else if (q.pd_units >= q.pd_delay) begin
      next_q.reduce = 1'b1;                              // [R12]
    end else if (q.tick_cnt >= PD_TICK_CYCLES - 1) begin
      next_q.tick_cnt = 32'h0;
      next_q.pd_units = q.pd_units + 9'h1;
    end else begin
      next_q.tick_cnt = q.tick_cnt + 32'h1;
    end

    // sticky interrupt status, write one to clear, set wins
    ev[`APSP_IRQ_STALL] = stall_ev;
    ev[`APSP_IRQ_DEV]   = dev_trip;
    ev[`APSP_IRQ_FAULT] = overtemp || short_a || short_b;
    if (wr && q.ap_idx == `APSP_IDX_IRQ_STATUS) begin
      next_q.irq_st = q.irq_st & ~hwdata[2:0];
    end
    next_q.irq_st = next_q.irq_st | ev;
    next_q.irq    = |(next_q.irq_st & next_q.irq_mask);
  end

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q          <= '0;
      q.pd_delay <= `APSP_RST_PD_DELAY;                  // [R13]
      q.unit     <= `APSP_RST_UNIT;                      // [R15]
      off_q      <= 1'b0;
    end else begin
      q          <= next_q;
      off_q      <= overtemp || short_a || short_b;      // [R06]
    end
  end

  // outputs straight from flip-flops, except hreadyout and hresp, which are tied to constants
  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign hrdata             = q.hrdata;
  assign motor_stop         = q.stop;
  assign current_reduce     = q.reduce;
  assign driver_off         = off_q;
  assign freewheel_mode     = q.freewheel;
  assign unit_pps           = q.unit;
  assign enc_counts_per_rev = q.enc_res;
  assign irq                = q.irq;

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_dev_sets_stop: assert property (dev_trip |=> motor_stop) // [R10]
    else $error("deviation did not stop motor");
  a_dev_sets_flag: assert property ( // [R16]
    dev_trip |=> q.ext_err[`APSP_EXT_DEV])
    else $error("deviation flag not set");
  a_zero_dev_off: assert property ( // [R11]
    q.max_dev == 16'h0 && !motion_cmd |=> !$rose(motor_stop))
    else $error("stop with monitor disabled");
  a_read_clears: assert property ( // [R03]
    rd_ext && !stall_ev && !dev_trip |=> q.ext_err == 2'h0)
    else $error("extended errors not cleared on read");
  a_motion_clears: assert property ( // [R04]
    motion_cmd && !stall_ev && !dev_trip |=> q.ext_err == 2'h0)
    else $error("motion command did not clear errors");
  a_short_fault: assert property ( // [R06]
    short_a |=> q.drv[`APSP_DRV_SHORT_A] && driver_off)
    else $error("short to ground not flagged");
  a_still_flag: assert property ( // [R08]
    step_pulse |=> !q.drv[`APSP_DRV_STILL])
    else $error("standstill set after step");
  a_reduce_step: assert property ( // [R12]
    step_pulse && q.pd_delay != 9'h0 |=>
      !current_reduce ##1 !current_reduce)
    else $error("current reduced right after step");
  a_open_load: assert property ( // [R07]
    coil_pol_a != q.pol_a && !q.chop_a |=> q.drv[`APSP_DRV_OPEN_A])
    else $error("open load A not flagged");
  a_irq_level: assert property (
    |(q.irq_st & q.irq_mask) |-> irq)
    else $error("interrupt not raised");

  // ----------------------------------------------------------
  // driver fault, error flag and current reduction checks
  // ----------------------------------------------------------
  // each fault level shows in its flag one cycle after it is seen
  a_drv_stall: assert property ( // [R05]
    stall_detect |=> q.drv[`APSP_DRV_STALL])
    else $error("stall fault not flagged");
  a_drv_otemp: assert property ( // [R05]
    overtemp |=> q.drv[`APSP_DRV_OTEMP] && driver_off)
    else $error("overtemperature not flagged");
  a_drv_prewarn: assert property ( // [R05]
    temp_prewarn |=> q.drv[`APSP_DRV_PREWARN])
    else $error("pre-warning not flagged");
  a_short_b: assert property ( // [R06]
    short_b |=> q.drv[`APSP_DRV_SHORT_B] && driver_off)
    else $error("short to ground B not flagged");
  // a stall always wins over a clear in the same cycle
  a_stall_flag: assert property ( // [R03]
    stall_ev |=> q.ext_err[`APSP_EXT_STALL])
    else $error("stall error flag not set");
  a_open_load_b: assert property ( // [R07]
    coil_pol_b != q.pol_b && !q.chop_b |=> q.drv[`APSP_DRV_OPEN_B])
    else $error("open load B not flagged");
  // standstill stays flagged while the counter sits at its limit
  a_still_set: assert property ( // [R08]
    q.still_cnt >= STILL_CYCLES && !step_pulse |=>
      q.drv[`APSP_DRV_STILL])
    else $error("standstill not flagged");
  a_reduce_set: assert property ( // [R12]
    !step_pulse && q.pd_units >= q.pd_delay |=> current_reduce)
    else $error("current not reduced after delay");

  c_dev_stop: cover property (dev_trip ##1 motor_stop);
  c_read_clear: cover property (rd_ext && q.ext_err != 2'h0);
  c_reduce: cover property ($rose(current_reduce));
  c_irq: cover property ($rose(irq));
  c_open_load: cover property ($rose(q.drv[`APSP_DRV_OPEN_A]));
endmodule : apsp_axis

/* core/apsp_cfg.svh */
// offsets, field positions, reset values and timing figures of the block
`ifndef APSP_CFG_SVH
`define APSP_CFG_SVH
// register indices; byte address is four times the index
`define APSP_IDX_FREEWHEEL   8'hCC
`define APSP_IDX_LOAD        8'hCE
`define APSP_IDX_EXT_ERR     8'hCF
`define APSP_IDX_DRV_FAULT   8'hD0
`define APSP_IDX_ENC_CNT     8'hD1
`define APSP_IDX_ENC_RES     8'hD2
`define APSP_IDX_MAX_DEV     8'hD4
`define APSP_IDX_PD_DELAY    8'hD6
`define APSP_IDX_IRQ_STATUS  8'hE0
`define APSP_IDX_IRQ_MASK    8'hE1
`define APSP_IDX_UNIT        8'hFF
// extended error flag positions
`define APSP_EXT_STALL       0
`define APSP_EXT_DEV         1
// driver fault flag positions
`define APSP_DRV_STALL       0
`define APSP_DRV_OTEMP       1
`define APSP_DRV_PREWARN     2
`define APSP_DRV_SHORT_A     3
`define APSP_DRV_SHORT_B     4
`define APSP_DRV_OPEN_A      5
`define APSP_DRV_OPEN_B      6
`define APSP_DRV_STILL       7
// interrupt status positions
`define APSP_IRQ_STALL       0
`define APSP_IRQ_DEV         1
`define APSP_IRQ_FAULT       2
// reset values
`define APSP_RST_PD_DELAY    9'h0C8
`define APSP_RST_UNIT        1'h1
// timing
`define APSP_CLK_PERIOD_NS   8
`define APSP_PD_UNIT_MS      10
`define APSP_STILL_LOG2      20
`endif

/* core/apsp_pkg.sv */
// types of the axis protection and status parameter block
package apsp_pkg;
  typedef struct packed {
    logic        ap_valid;
    logic        ap_write;
    logic [7:0]  ap_idx;
    logic [31:0] hrdata;
    logic [1:0]  freewheel;
    logic [1:0]  ext_err;
    logic [7:0]  drv;
    logic [31:0] enc_cnt;
    logic [15:0] enc_res;
    logic [15:0] max_dev;
    logic [8:0]  pd_delay;
    logic        unit;
    logic [2:0]  irq_st;
    logic [2:0]  irq_mask;
    logic        irq;
    logic [31:0] still_cnt;
    logic [31:0] tick_cnt;
    logic [8:0]  pd_units;
    logic        reduce;
    logic        stop;
    logic        chop_a;
    logic        chop_b;
    logic        pol_a;
    logic        pol_b;
  } apsp_state_s;
endpackage : apsp_pkg

/* testbench/apsp_axis_tb.sv */
// self-checking bench of the axis protection and status block
`timescale 1ns/1ps
`include "apsp_cfg.svh"
module apsp_axis_tb;
  import apsp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans, freewheel_mode;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, actual_pos, rd;
  logic [9:0]  load_value;
  logic        stall_detect, overtemp, temp_prewarn, short_a, short_b;
  logic        chop_event_a, chop_event_b, coil_pol_a, coil_pol_b;
  logic        step_pulse, motion_cmd, enc_up, enc_down, run_step;
  logic        run_enc, chop_ok, motor_stop, current_reduce, driver_off;
  logic        unit_pps, irq;
  logic [15:0] enc_counts_per_rev;
  int          fails, n_compared;

  apsp_axis #(.STILL_CYCLES(16), .PD_TICK_CYCLES(4)) DUT (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .load_value(load_value), .stall_detect(stall_detect),
    .overtemp(overtemp), .temp_prewarn(temp_prewarn), .short_a(short_a),
    .short_b(short_b), .chop_event_a(chop_event_a),
    .chop_event_b(chop_event_b), .coil_pol_a(coil_pol_a),
    .coil_pol_b(coil_pol_b), .step_pulse(step_pulse),
    .motion_cmd(motion_cmd), .actual_pos(actual_pos), .enc_up(enc_up),
    .enc_down(enc_down), .motor_stop(motor_stop),
    .current_reduce(current_reduce), .driver_off(driver_off),
    .freewheel_mode(freewheel_mode), .unit_pps(unit_pps),
    .enc_counts_per_rev(enc_counts_per_rev), .irq(irq));

  apsp_drv_model FAR (.hclk(hclk), .hresetn(hresetn), .run_step(run_step),
    .run_enc(run_enc), .chop_ok(chop_ok), .step_pulse(step_pulse),
    .enc_up(enc_up), .enc_down(enc_down), .chop_event_a(chop_event_a),
    .chop_event_b(chop_event_b), .coil_pol_a(coil_pol_a),
    .coil_pol_b(coil_pol_b));

  // ------------------------------------------------------------
  // clock, tasks
  // ------------------------------------------------------------
  initial hclk = 1'b0;
  always #4 hclk = ~hclk;

  task automatic give_verdict();
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h000000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rchk(input string nm, input logic [7:0] idx,
                      input logic [31:0] e);
    bus(1'b0, idx, 32'h00000000);
    chk(nm, e, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rchk

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {stall_detect, overtemp, temp_prewarn, short_a, short_b} = '0;
    {motion_cmd, run_step, run_enc, chop_ok, actual_pos} = '0;
    {fails, n_compared} = '0;
    hsize = 3'h2;
    load_value = 10'h000;
    cyc(8);
    hresetn <= 1'b1;
    rchk("pd_delay", `APSP_IDX_PD_DELAY, 32'h000000C8);
    rchk("unit", `APSP_IDX_UNIT, 32'h00000001);
    chk("unit_pps", 32'h1, {31'h0, unit_pps});
    bus(1'b1, `APSP_IDX_FREEWHEEL, 32'h00000003);
    rchk("freewheel", `APSP_IDX_FREEWHEEL, 32'h00000003);
    chk("fw_mode", 32'h3, {30'h0, freewheel_mode});
    bus(1'b1, `APSP_IDX_UNIT, 32'h00000000);
    cyc(1);
    chk("unit_pps", 32'h0, {31'h0, unit_pps});
    bus(1'b1, `APSP_IDX_ENC_RES, 32'h0000FFFF);
    rchk("enc_res", `APSP_IDX_ENC_RES, 32'h0000FFFF);
    chk("cpr", 32'hFFFF, {16'h0, enc_counts_per_rev});
    load_value <= 10'h3FF;
    bus(1'b1, `APSP_IDX_LOAD, 32'h00000000);
    rchk("load", `APSP_IDX_LOAD, 32'h000003FF);
    rchk("unmapped", 8'h10, 32'h00000000);
    // each fault level alone; motor idle so standstill is set
    for (int i = 0; i < 5; i++) begin
      {short_b, short_a, temp_prewarn, overtemp, stall_detect} <= 5'h01 << i;
      rchk("drv", `APSP_IDX_DRV_FAULT, 32'h80 | (32'h1 << i));
      chk("drv_off", {31'h0, i inside {1, 3, 4}}, {31'h0, driver_off});
    end
    {short_b, short_a, temp_prewarn, overtemp, stall_detect} <= 5'h00;
    rchk("ext_err", `APSP_IDX_EXT_ERR, 32'h00000001);
    rchk("ext_err", `APSP_IDX_EXT_ERR, 32'h00000000);
    stall_detect <= 1'b1;
    cyc(1);
    stall_detect <= 1'b0;
    motion_cmd   <= 1'b1;
    cyc(1);
    motion_cmd   <= 1'b0;
    rchk("ext_err", `APSP_IDX_EXT_ERR, 32'h00000000);
    bus(1'b1, `APSP_IDX_IRQ_STATUS, 32'h00000007);
    rchk("irq_st", `APSP_IDX_IRQ_STATUS, 32'h00000000);
    // deviation monitor: off, at limit, beyond limit
    bus(1'b1, `APSP_IDX_ENC_CNT, 32'h00000000);
    actual_pos <= 32'd100;
    cyc(4);
    chk("stop", 32'h0, {31'h0, motor_stop});
    bus(1'b1, `APSP_IDX_IRQ_MASK, 32'h00000002);
    bus(1'b1, `APSP_IDX_MAX_DEV, 32'h00000064);
    cyc(3);
    chk("stop", 32'h0, {31'h0, motor_stop});
    actual_pos <= 32'd101;
    cyc(3);
    chk("stop", 32'h1, {31'h0, motor_stop});
    chk("irq", 32'h1, {31'h0, irq});
    rchk("ext_err", `APSP_IDX_EXT_ERR, 32'h00000002);
    actual_pos <= 32'd0;
    motion_cmd <= 1'b1;
    cyc(1);
    motion_cmd <= 1'b0;
    bus(1'b1, `APSP_IDX_IRQ_STATUS, 32'h00000002);
    cyc(2);
    chk("irq", 32'h0, {31'h0, irq});
    chk("stop", 32'h0, {31'h0, motor_stop});
    // encoder counting across the word boundary
    bus(1'b1, `APSP_IDX_MAX_DEV, 32'h00000000);
    bus(1'b1, `APSP_IDX_ENC_CNT, 32'hFFFFFFFE);
    run_enc <= 1'b1;
    cyc(3);
    run_enc <= 1'b0;
    rchk("enc", `APSP_IDX_ENC_CNT, 32'h00000001);
    // stepping, standstill and current reduction
    bus(1'b1, `APSP_IDX_PD_DELAY, 32'h00000002);
    {chop_ok, run_step} <= 2'h3;
    cyc(24);
    run_step <= 1'b0;
    rchk("drv", `APSP_IDX_DRV_FAULT, 32'h00000000);
    chk("reduce", 32'h0, {31'h0, current_reduce});
    cyc(40);
    rchk("drv", `APSP_IDX_DRV_FAULT, 32'h00000080);
    chk("reduce", 32'h1, {31'h0, current_reduce});
    {chop_ok, run_step} <= 2'h1;
    cyc(24);
    run_step <= 1'b0;
    rchk("drv", `APSP_IDX_DRV_FAULT, 32'h00000060);
    give_verdict();
  end

  // watchdog against a hung transfer
  initial begin
    #160000;
    fails++;
    give_verdict();
  end
endmodule : apsp_axis_tb

/* testbench/apsp_drv_model.sv */
// driver stage and encoder model facing the axis block
`timescale 1ns/1ps
module apsp_drv_model (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // bench controls
  input  wire logic run_step,
  input  wire logic run_enc,
  input  wire logic chop_ok,
  // driver and encoder lines
  output      logic step_pulse,
  output      logic enc_up,
  output      logic enc_down,
  output      logic chop_event_a,
  output      logic chop_event_b,
  output      logic coil_pol_a,
  output      logic coil_pol_b
);
  logic [2:0] phase;
  // steps every other cycle; coil polarity follows the step phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {phase, step_pulse, enc_up, enc_down} <= '0;
      {chop_event_a, chop_event_b, coil_pol_a, coil_pol_b} <= '0;
    end else begin
      step_pulse   <= run_step & ~step_pulse;
      phase        <= phase + {2'h0, step_pulse};
      coil_pol_a   <= phase[1];
      coil_pol_b   <= phase[2];
      chop_event_a <= chop_ok & step_pulse; // no chop means open coil
      chop_event_b <= chop_ok & step_pulse;
      enc_up       <= run_enc;
      enc_down     <= 1'b0;
    end
  end
endmodule : apsp_drv_model
